// ===== common/plas_pkg.sv
// Package for the proximity LED select and result alignment block
package plas_pkg;
    // Parameter offsets
    localparam logic [7:0] OFS_LED12 = 8'h02;
    localparam logic [7:0] OFS_IR_DRIVER_THREE = 8'h03;
    localparam logic [7:0] OFS_PS_ALIGN = 8'h05;
    localparam logic [7:0] OFS_ALS_ALIGN = 8'h06;
    localparam logic [7:0] OFS_CHAN_EN = 8'h01;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // Reset values
    localparam logic [7:0] RST_LED12 = 8'h21;
    localparam logic [7:0] RST_IR_DRIVER_THREE = 8'h04;
    localparam logic [7:0] RST_PS_ALIGN = 8'h00;
    localparam logic [7:0] RST_ALS_ALIGN = 8'h00;
    localparam logic [7:0] RST_CHAN_EN = 8'h00;
    // Writable bit masks, reserved bits held at zero
    localparam logic [7:0] WMASK_LED12 = 8'h77;
    localparam logic [7:0] WMASK_IR_DRIVER_THREE = 8'h07;
    localparam logic [7:0] WMASK_PS_ALIGN = 8'h70;
    localparam logic [7:0] WMASK_ALS_ALIGN = 8'h30;
    localparam logic [7:0] WMASK_CHAN_EN = 8'hf7;
    // Field positions
    localparam int POS_CH1_LED = 0;
    localparam int POS_CH2_LED = 4;
    localparam int POS_CH3_LED = 0;
    localparam int POS_CH1_LOW_BITS = 4;
    localparam int POS_ALS_BIT4 = 4;
    localparam int POS_ALS_BIT5 = 5;
    localparam int POS_EN_VIS = 4;
    localparam int POS_EN_IR = 5;
    // Measurement channel codes
    localparam logic [2:0] CH_PS1 = 3'h0;
    localparam logic [2:0] CH_PS2 = 3'h1;
    localparam logic [2:0] CH_PS3 = 3'h2;
    localparam logic [2:0] CH_VIS = 3'h3;
    localparam logic [2:0] CH_IR = 3'h4;
    // Sequencer state
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MEAS = 3'b010,
        ST_DONE = 3'b100
    } plas_state_t;
endpackage

// ===== design/plas_align.sv
// Picks upper or lower 16 bits of a 17-bit conversion
`timescale 1ns/1ns
module plas_align
    import plas_pkg::*;
(
    input wire logic [16:0] conv_i,
    input wire logic low_bits_i,
    output logic [15:0] result_o
);
    // Low bits drop the MSB, upper bits drop the LSB
    always_comb begin
        if (low_bits_i) begin
            result_o = conv_i[15:0];
        end else begin
            result_o = conv_i[16:1];
        end
    end
endmodule

// ===== design/plas_regs.sv
// Parameter store for LED select, alignment and channel enable
`timescale 1ns/1ns
module plas_regs
    import plas_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    output logic [7:0] led12_o,
    output logic [7:0] ir_driver_three_o,
    output logic [7:0] ps_align_o,
    output logic [7:0] als_align_o,
    output logic [7:0] chan_en_o
);
    typedef struct packed {
        logic [7:0] prox_led_select_ch1_ch2;
        logic [7:0] prox_led_select_ch3;
        logic [7:0] prox_result_alignment;
        logic [7:0] ambient_result_alignment;
        logic [7:0] channel_enable_list;
    } plas_regs_t;

    plas_regs_t r;
    plas_regs_t next_r;

    // Reserved bits are masked so they always read zero
    always_comb begin
        next_r = r;
        if (wr_i) begin
            if (addr_i == OFS_LED12) begin
                next_r.prox_led_select_ch1_ch2 = wdata_i & WMASK_LED12;
            end else if (addr_i == OFS_IR_DRIVER_THREE) begin
                next_r.prox_led_select_ch3 = wdata_i & WMASK_IR_DRIVER_THREE;
            end else if (addr_i == OFS_PS_ALIGN) begin
                next_r.prox_result_alignment = wdata_i & WMASK_PS_ALIGN;
            end else if (addr_i == OFS_ALS_ALIGN) begin
                next_r.ambient_result_alignment = wdata_i & WMASK_ALS_ALIGN;
            end else if (addr_i == OFS_CHAN_EN) begin
                next_r.channel_enable_list = wdata_i & WMASK_CHAN_EN;
            end
        end
    end

    // Reset values per parameter
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            r.prox_led_select_ch1_ch2 <= RST_LED12;
            r.prox_led_select_ch3 <= RST_IR_DRIVER_THREE;
            r.prox_result_alignment <= RST_PS_ALIGN;
            r.ambient_result_alignment <= RST_ALS_ALIGN;
            r.channel_enable_list <= RST_CHAN_EN;
        end else begin
            r <= next_r;
        end
    end

    assign led12_o = r.prox_led_select_ch1_ch2;
    assign ir_driver_three_o = r.prox_led_select_ch3;
    assign ps_align_o = r.prox_result_alignment;
    assign als_align_o = r.ambient_result_alignment;
    assign chan_en_o = r.channel_enable_list;
endmodule

// ===== design/plas_top.sv
// Top of the proximity LED select and result alignment block
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module plas_top
    import plas_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic meas_start_i,
    input wire logic [2:0] meas_chan_i,
    input wire logic [16:0] conv_i,
    input wire logic conv_valid_i,
    output logic [2:0] led_drive_o,
    output logic [15:0] result_o,
    output logic result_valid_o,
    output logic [2:0] result_chan_o,
    output logic busy_o
);
    typedef struct packed {
        plas_state_t state;
        logic [2:0] chan;
        logic [2:0] led;
        logic [7:0] rdata;
        logic [15:0] result;
        logic rvalid;
        logic [2:0] rchan;
        logic busy;
    } plas_top_t;

    plas_top_t s;
    plas_top_t next_s;
    logic [7:0] led12;
    logic [7:0] ir_driver_three;
    logic [7:0] ps_align;
    logic [7:0] als_align;
    logic [7:0] chan_en;
    logic low_bits;
    logic [15:0] aligned;

    // LED mask of a channel; bit0 driver one, bit1 two, bit2 three
    function automatic logic [2:0] led_mask(input logic [2:0] ch,
                                            input logic [7:0] l12,
                                            input logic [7:0] l3);
        logic [2:0] m;
        m = 3'h0;
        if (ch == CH_PS1) begin
            m = l12[POS_CH1_LED +: 3];
        end else if (ch == CH_PS2) begin
            m = l12[POS_CH2_LED +: 3];
        end else if (ch == CH_PS3) begin
            m = l3[POS_CH3_LED +: 3];
        end
        return m;
    endfunction

    // Alignment bit of a channel; ambient bits cross-named on purpose
    function automatic logic align_bit(input logic [2:0] ch,
                                       input logic [7:0] pa,
                                       input logic [7:0] aa);
        logic b;
        b = 1'b0;
        if (ch == CH_PS1 || ch == CH_PS2 || ch == CH_PS3) begin
            b = pa[POS_CH1_LOW_BITS + 32'(ch)];
        end else if (ch == CH_VIS) begin
            b = aa[POS_ALS_BIT5];
        end else if (ch == CH_IR) begin
            b = aa[POS_ALS_BIT4];
        end
        return b;
    endfunction

    // Enable bit of a channel in the channel enable list
    function automatic logic chan_on(input logic [2:0] ch,
                                     input logic [7:0] en);
        logic b;
        b = 1'b0;
        if (ch == CH_PS1 || ch == CH_PS2 || ch == CH_PS3) begin
            b = en[ch];
        end else if (ch == CH_VIS) begin
            b = en[POS_EN_VIS];
        end else if (ch == CH_IR) begin
            b = en[POS_EN_IR];
        end
        return b;
    endfunction

    plas_regs u_regs (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .led12_o(led12),
        .ir_driver_three_o(ir_driver_three),
        .ps_align_o(ps_align),
        .als_align_o(als_align),
        .chan_en_o(chan_en)
    );

    // Alignment is sampled from live settings at conversion end
    assign low_bits = align_bit(s.chan, ps_align, als_align);

    plas_align u_align (
        .conv_i(conv_i),
        .low_bits_i(low_bits),
        .result_o(aligned)
    );

    // Sequencer and read decode
    always_comb begin
        next_s = s;
        next_s.rvalid = 1'b0;
        next_s.rdata = 8'h00;
        if (rd_i) begin
            if (addr_i == OFS_LED12) begin
                next_s.rdata = led12;
            end else if (addr_i == OFS_IR_DRIVER_THREE) begin
                next_s.rdata = ir_driver_three;
            end else if (addr_i == OFS_PS_ALIGN) begin
                next_s.rdata = ps_align;
            end else if (addr_i == OFS_ALS_ALIGN) begin
                next_s.rdata = als_align;
            end else if (addr_i == OFS_CHAN_EN) begin
                next_s.rdata = chan_en;
            end else if (addr_i == OFS_STATUS) begin
                next_s.rdata = {2'h0, s.led, s.state != ST_IDLE, s.chan[1:0]};
            end
        end
        case (s.state)
            ST_IDLE: begin
                // Disabled channels are ignored, which is why the host
                // must enable them first
                if (meas_start_i && chan_on(meas_chan_i, chan_en)) begin
                    next_s.state = ST_MEAS;
                    next_s.chan = meas_chan_i;
                    next_s.led = led_mask(meas_chan_i, led12, ir_driver_three);
                end
            end
            ST_MEAS: begin
                if (conv_valid_i) begin
                    next_s.state = ST_DONE;
                    next_s.led = 3'h0;
                    next_s.result = aligned;
                    next_s.rvalid = 1'b1;
                    next_s.rchan = s.chan;
                end
            end
            ST_DONE: begin
                next_s.state = ST_IDLE;
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase
        // Busy registered so the output never glitches on state decode
        next_s.busy = next_s.state != ST_IDLE;
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            s.state <= ST_IDLE;
            s.chan <= 3'h0;
            s.led <= 3'h0;
            s.rdata <= 8'h00;
            s.result <= 16'h0000;
            s.rvalid <= 1'b0;
            s.rchan <= 3'h0;
            s.busy <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_o = s.rdata;
    assign led_drive_o = s.led;
    assign result_o = s.result;
    assign result_valid_o = s.rvalid;
    assign result_chan_o = s.rchan;
    assign busy_o = s.busy;

    // Mask captured at the start equals the select field of that cycle
    a_led_ch1: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_IDLE && meas_start_i && meas_chan_i == CH_PS1
         && chan_en[0]) |=> led_drive_o == $past(led12[POS_CH1_LED +: 3]))
        else $error("channel one LED mask wrong");
    a_led_ch2: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_IDLE && meas_start_i && meas_chan_i == CH_PS2
         && chan_en[1]) |=> led_drive_o == $past(led12[POS_CH2_LED +: 3]))
        else $error("channel two LED mask wrong");
    a_led_ch3: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_IDLE && meas_start_i && meas_chan_i == CH_PS3
         && chan_en[2]) |=> led_drive_o == $past(ir_driver_three[POS_CH3_LED +: 3]))
        else $error("channel three LED mask wrong");

    // Drive holds through the conversion and drops once it completes
    a_led_hold: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_MEAS && !conv_valid_i) |=> $stable(led_drive_o))
        else $error("LED drive changed mid measurement");
    a_led_release: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_MEAS && conv_valid_i) |=> led_drive_o == 3'h0)
        else $error("LED drive left on after conversion");
    a_led_idle: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        s.state == ST_IDLE |-> led_drive_o == 3'h0)
        else $error("LED driven while idle");

    // Ambient measurements never fire an LED driver
    a_ambient_dark: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_IDLE && meas_start_i
         && (meas_chan_i == CH_VIS || meas_chan_i == CH_IR))
        |=> led_drive_o == 3'h0)
        else $error("LED driven for ambient measurement");

    // Reserved select and alignment bits are held at zero
    a_select_reserved: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        led12[7] == 1'b0 && led12[3] == 1'b0 && ir_driver_three[7:3] == 5'h00)
        else $error("reserved select bit set");
    a_align_reserved: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        ps_align[7] == 1'b0 && ps_align[3:0] == 4'h0
        && als_align[7:6] == 2'h0 && als_align[3:0] == 4'h0)
        else $error("reserved alignment bit set");

    // Checked at each release of reset, mid-run ones included
    a_reset_select: assert property (
        @(posedge clock_i)
        (!sys_rst_i && $past(sys_rst_i))
        |-> led12 == RST_LED12 && ir_driver_three == RST_IR_DRIVER_THREE)
        else $error("select reset value wrong");
    a_reset_align: assert property (
        @(posedge clock_i)
        (!sys_rst_i && $past(sys_rst_i))
        |-> ps_align == RST_PS_ALIGN && als_align == RST_ALS_ALIGN)
        else $error("alignment reset value wrong");

    // Result halves follow the channel's alignment bit at conversion end
    a_prox1_align: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_MEAS && conv_valid_i && s.chan == CH_PS1) |=>
        result_o == ($past(ps_align[4]) ? $past(conv_i[15:0])
                                        : $past(conv_i[16:1])))
        else $error("proximity one alignment wrong");
    a_prox2_align: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_MEAS && conv_valid_i && s.chan == CH_PS2) |=>
        result_o == ($past(ps_align[5]) ? $past(conv_i[15:0])
                                        : $past(conv_i[16:1])))
        else $error("proximity two alignment wrong");
    a_prox3_align: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_MEAS && conv_valid_i && s.chan == CH_PS3) |=>
        result_o == ($past(ps_align[6]) ? $past(conv_i[15:0])
                                        : $past(conv_i[16:1])))
        else $error("proximity three alignment wrong");
    a_vis_align: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_MEAS && conv_valid_i && s.chan == CH_VIS) |=>
        result_o == ($past(als_align[5]) ? $past(conv_i[15:0])
                                         : $past(conv_i[16:1])))
        else $error("visible alignment wrong");
    a_ir_align: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_MEAS && conv_valid_i && s.chan == CH_IR) |=>
        result_o == ($past(als_align[4]) ? $past(conv_i[15:0])
                                         : $past(conv_i[16:1])))
        else $error("infrared alignment wrong");

    // Result stands until the next conversion; valid is one pulse
    a_result_hold: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        !(s.state == ST_MEAS && conv_valid_i) |=> $stable(result_o))
        else $error("result changed without a conversion");
    a_valid_pulse: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        result_valid_o |=> !result_valid_o)
        else $error("result valid longer than one cycle");
    a_result_chan: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_MEAS && conv_valid_i)
        |=> result_chan_o == $past(s.chan))
        else $error("result channel wrong");

    // A start while busy is refused, so the channel cannot change
    a_busy_keep: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        s.state == ST_MEAS |=> s.chan == $past(s.chan) && busy_o)
        else $error("measurement channel changed while busy");
    a_start_off: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s.state == ST_IDLE && meas_chan_i == CH_PS1 && !chan_en[0])
        |=> !busy_o)
        else $error("disabled channel started");

    // Parameters read back as stored, one cycle after the strobe
    a_read_select: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (rd_i && addr_i == OFS_LED12) |=> rdata_o == $past(led12))
        else $error("select read back wrong");
    a_read_align: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (rd_i && addr_i == OFS_PS_ALIGN) |=> rdata_o == $past(ps_align))
        else $error("alignment read back wrong");
endmodule

// ===== test/plas_host.sv
// Host model driving the parameter store over the register port
`timescale 1ns/1ns
module plas_host
    import plas_pkg::*;
(
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // Bus idle from time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Writable bits per offset; a full variant, so every driver is present
    function automatic logic [7:0] keep(input logic [7:0] a);
        case (a)
            OFS_LED12: keep = 8'h77;
            OFS_IR_DRIVER_THREE: keep = 8'h07;
            OFS_PS_ALIGN: keep = 8'h70;
            OFS_ALS_ALIGN: keep = 8'h30;
            default: keep = 8'hff;
        endcase
    endfunction

    // One-cycle write, reserved bits sent as zero except at OFS_CHAN_EN, which goes out unmasked
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        wdata_o <= d & keep(a);
        wr_o <= 1'b1;
        @(posedge clock_i);
        wr_o <= 1'b0;
    endtask

    // One-cycle read; data taken only in the following cycle
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clock_i);
        rd_o <= 1'b0;
        @(posedge clock_i);
        d = rdata_i;
    endtask

    // Channels must be on before any measurement is asked for
    task automatic enable_channels();
        write_reg(OFS_CHAN_EN, 8'h37);
    endtask
endmodule

// ===== test/prox_led_select_adc_align_test.sv
// Self-checking bench for LED select and result alignment
`timescale 1ns/1ns
module prox_led_select_adc_align_test
    import plas_pkg::*;
;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic wr_i, rd_i, result_valid_o, busy_o;
    logic meas_start_i = 1'b0;
    logic [2:0] meas_chan_i = 3'h0;
    logic [16:0] conv_i = 17'h0;
    logic conv_valid_i = 1'b0;
    logic [2:0] led_drive_o, result_chan_o;
    logic [15:0] result_o;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    plas_top DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .meas_start_i(meas_start_i),
        .meas_chan_i(meas_chan_i), .conv_i(conv_i),
        .conv_valid_i(conv_valid_i), .led_drive_o(led_drive_o),
        .result_o(result_o), .result_valid_o(result_valid_o),
        .result_chan_o(result_chan_o), .busy_o(busy_o));
    plas_host host (.clock_i(clock_i), .rdata_i(rdata_o), .addr_o(addr_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

    // 50 MHz clock
    initial begin
        forever #10 clock_i = ~clock_i;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        check({9'h0, d}, {9'h0, exp});
    endtask

    // Full measurement walk; the conversion differs between its halves
    task automatic meas(input logic [2:0] ch, input logic [2:0] led,
                        input logic low);
        logic [16:0] cv;
        cv = 17'h1a5c3 ^ {14'h0, ch};
        @(posedge clock_i);
        meas_start_i <= 1'b1;
        meas_chan_i <= ch;
        @(posedge clock_i);
        meas_start_i <= 1'b0;
        @(posedge clock_i);
        check({14'h0, led_drive_o}, {14'h0, led});
        check({16'h0, busy_o}, 17'h1);
        conv_i <= cv;
        conv_valid_i <= 1'b1;
        @(posedge clock_i);
        conv_valid_i <= 1'b0;
        @(posedge clock_i);
        check({16'h0, result_valid_o}, 17'h1);
        check({1'b0, result_o}, low ? cv[15:0] : cv[16:1]);
        check({14'h0, result_chan_o}, {14'h0, ch});
        check({14'h0, led_drive_o}, 17'h0);
        @(posedge clock_i);
        check({16'h0, busy_o}, 17'h0);
    endtask

    initial begin
        logic [2:0] m;
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        // Reset values, then an unmapped offset
        rd(OFS_LED12, 8'h21);
        rd(OFS_IR_DRIVER_THREE, 8'h04);
        rd(OFS_PS_ALIGN, 8'h00);
        rd(OFS_ALS_ALIGN, 8'h00);
        rd(8'h10, 8'h00);
        host.enable_channels();
        rd(OFS_CHAN_EN, 8'h37);
        // Defaults: one LED per proximity channel, upper bits reported
        meas(CH_PS1, 3'h1, 1'b0);
        meas(CH_PS2, 3'h2, 1'b0);
        meas(CH_PS3, 3'h4, 1'b0);
        meas(CH_VIS, 3'h0, 1'b0);
        meas(CH_IR, 3'h0, 1'b0);
        // Every LED combination, channel two given the complement
        for (int i = 0; i < 8; i++) begin
            m = i[2:0];
            host.write_reg(OFS_LED12, {1'b0, ~m, 1'b0, m});
            host.write_reg(OFS_IR_DRIVER_THREE, {5'h0, m});
            rd(OFS_LED12, {1'b0, ~m, 1'b0, m});
            meas(CH_PS1, m, 1'b0);
            meas(CH_PS2, ~m, 1'b0);
            meas(CH_PS3, m, 1'b0);
        end
        // Every proximity alignment pattern
        for (int i = 0; i < 8; i++) begin
            host.write_reg(OFS_PS_ALIGN, {1'b0, i[2:0], 4'h0});
            meas(CH_PS1, 3'h7, i[0]);
            meas(CH_PS2, 3'h0, i[1]);
            meas(CH_PS3, 3'h7, i[2]);
        end
        // Ambient: bit 5 steers visible, bit 4 infrared
        for (int i = 0; i < 4; i++) begin
            host.write_reg(OFS_ALS_ALIGN, {2'h0, i[1:0], 4'h0});
            rd(OFS_ALS_ALIGN, {2'h0, i[1:0], 4'h0});
            meas(CH_VIS, 3'h0, i[1]);
            meas(CH_IR, 3'h0, i[0]);
        end
        // Status mid-measurement; a second start while busy is refused
        @(posedge clock_i);
        meas_start_i <= 1'b1;
        meas_chan_i <= CH_PS3;
        @(posedge clock_i);
        meas_chan_i <= CH_PS1;
        @(posedge clock_i);
        meas_start_i <= 1'b0;
        rd(OFS_STATUS, {2'h0, 3'h7, 1'b1, 2'h2});
        conv_i <= 17'h10001;
        conv_valid_i <= 1'b1;
        @(posedge clock_i);
        conv_valid_i <= 1'b0;
        @(posedge clock_i);
        check({14'h0, result_chan_o}, {14'h0, CH_PS3});
        check({16'h0, result_valid_o}, 17'h1);
        check({1'b0, result_o}, 17'h00001);
        // Mid-run reset restores defaults and switches channels off
        @(posedge clock_i);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        meas_start_i <= 1'b1;
        meas_chan_i <= CH_PS1;
        @(posedge clock_i);
        meas_start_i <= 1'b0;
        @(posedge clock_i);
        check({16'h0, busy_o}, 17'h0);
        check({14'h0, led_drive_o}, 17'h0);
        rd(OFS_LED12, 8'h21);
        rd(OFS_IR_DRIVER_THREE, 8'h04);
        rd(OFS_PS_ALIGN, 8'h00);
        rd(OFS_ALS_ALIGN, 8'h00);
        rd(OFS_CHAN_EN, 8'h00);
        complete_run();
    end
endmodule
